// file: hsc_defs.svh
// register map, field positions, reset values and timing constants
`ifndef HSC_DEFS_SVH
`define HSC_DEFS_SVH
// register indices; byte address is four times the index
`define HSC_IDX_CTRL      8'h38
`define HSC_IDX_STAT      8'h39
`define HSC_IDX_HWCFG     8'h3c
`define HSC_IDX_TF_1F0    8'h40
`define HSC_IDX_TF_1F7    8'h44
`define HSC_IDX_STROBE    8'h60
// handshake polarity register fields
`define HSC_SWAP_HI       7
`define HSC_SWAP_LO       6
`define HSC_END_OF_TRANSFER_POLARITY       5
`define HSC_MASTER        4
`define HSC_ACKNOWLEDGE_POLARITY       3
`define HSC_REQ_POL       2
`define HSC_WR_POL        1
`define HSC_RD_POL        0
`define HSC_HWCFG_RST     8'h04
`define HSC_SWAP_NORMAL   2'h0
`define HSC_SWAP_SWAPPED  2'h1
// strobe length register
`define HSC_STB_RST       5'h1f
// control register fields
`define HSC_CTL_MODE_HI   1
`define HSC_CTL_MODE_LO   0
`define HSC_CTL_WIDE      2
`define HSC_CTL_DIR       3
`define HSC_CTL_GO        4
`define HSC_MODE_PROG     2'h3
// status register fields
`define HSC_ST_BUSY       0
`define HSC_ST_EOT        1
`define HSC_ST_RX_LO      16
// answers
`define HSC_TF_CMD_READ   8'hff
`define HSC_RESP_OKAY     2'h0
`define HSC_RESP_SLVERR   2'h2
// timing
`define HSC_CLK_PERIOD_PS 40000
`define HSC_PIO_STB_NS    165
`define HSC_DMA_STB_NS    120
`endif

// file: hsc_pkg.sv
// types shared by the handshake configuration block
package hsc_pkg;
  typedef enum logic [2:0] {
    HSC_IDLE  = 3'b000,
    HSC_PIO   = 3'b001,
    HSC_DMA   = 3'b010,
    HSC_WRESP = 3'b011,
    HSC_RRESP = 3'b100
  } hsc_state_t;
endpackage : hsc_pkg

// file: hsc_strobe_timer.sv
// strobe length down-counter shared by pio and dma cycles
`timescale 1ns/1ps
module hsc_strobe_timer #(
  parameter int LW = 6
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          start,
  input  wire logic [LW-1:0] len,
  output logic               busy,
  output logic               done
);
  logic [LW-1:0] count_q;
  logic [LW-1:0] count_d;

  // a start while idle loads the length; busy lasts exactly len cycles
  always_comb begin
    count_d = count_q;
    if (start && count_q == '0) begin
      count_d = len;
    end else if (count_q != '0) begin
      count_d = count_q - LW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign busy = (count_q != '0);
  assign done = (count_q == LW'(1));

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_TMR_LOAD: assert property (
    (start && !busy) |=> count_q == $past(len))
    else $error("strobe timer did not load its length");
endmodule : hsc_strobe_timer

// file: hsc_dma_bus_handshake.sv
// dma handshake polarity, strobe timing and task file pio bridge
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "hsc_defs.svh"
module hsc_dma_bus_handshake
  import hsc_pkg::*;
#(
  parameter int AW        = 10,
  parameter int PIO_NS    = `HSC_PIO_STB_NS,
  parameter int DMA_NS    = `HSC_DMA_STB_NS
) (
  input  wire logic          CLK,
  input  wire logic          RST,
  input  wire logic [AW-1:0] S_AXI_AWADDR,
  input  wire logic          S_AXI_AWVALID,
  output logic               S_AXI_AWREADY,
  input  wire logic [31:0]   S_AXI_WDATA,
  input  wire logic [3:0]    S_AXI_WSTRB,
  input  wire logic          S_AXI_WVALID,
  output logic               S_AXI_WREADY,
  output logic [1:0]         S_AXI_BRESP,
  output logic               S_AXI_BVALID,
  input  wire logic          S_AXI_BREADY,
  input  wire logic [AW-1:0] S_AXI_ARADDR,
  input  wire logic          S_AXI_ARVALID,
  output logic               S_AXI_ARREADY,
  output logic [31:0]        S_AXI_RDATA,
  output logic [1:0]         S_AXI_RRESP,
  output logic               S_AXI_RVALID,
  input  wire logic          S_AXI_RREADY,
  input  wire logic          DMA_REQ_IN,
  input  wire logic [15:0]   DMA_TX_DATA,
  output logic [15:0]        DMA_RX_DATA,
  output logic               DMA_RX_VALID,
  output logic               DMA_ACK_SEEN,
  output logic               DMA_EOT_SEEN,
  output logic               DMA_REQUEST,
  input  wire logic          DMA_ACKNOWLEDGE_I,
  output logic               DMA_ACKNOWLEDGE_O,
  output logic               DMA_ACKNOWLEDGE_OE_N,
  input  wire logic          END_OF_TRANSFER_INPUT,
  output logic               DEVICE_IO_READ_STROBE,
  output logic               DEVICE_IO_WRITE_STROBE,
  output logic               TF_CS1,
  output logic               TF_CS0,
  output logic [2:0]         TF_DA,
  input  wire logic [15:0]   DD_I,
  output logic [15:0]        DD_O,
  output logic               DD_OE_N
);
  // ==========================================================
  // timing constants
  localparam int PIO_CYC = (PIO_NS * 1000 + `HSC_CLK_PERIOD_PS - 1)
                           / `HSC_CLK_PERIOD_PS;
  localparam int DMA_CYC = (DMA_NS * 1000 + `HSC_CLK_PERIOD_PS - 1)
                           / `HSC_CLK_PERIOD_PS;
  localparam logic [5:0] PIO_LEN = 6'(PIO_CYC);
  localparam logic [5:0] DMA_LEN = 6'(DMA_CYC);

  // task file index to {hit, cs1, cs0, da}
  function automatic logic [5:0] tf_decode(input logic [7:0] idx);
    unique case (idx)
      8'h40:   tf_decode = 6'b110000;
      8'h48:   tf_decode = 6'b110001;
      8'h49:   tf_decode = 6'b110010;
      8'h4a:   tf_decode = 6'b110011;
      8'h4b:   tf_decode = 6'b110100;
      8'h4c:   tf_decode = 6'b110101;
      8'h4d:   tf_decode = 6'b110110;
      8'h44:   tf_decode = 6'b110111;
      8'h4e:   tf_decode = 6'b101110;
      8'h4f:   tf_decode = 6'b101111;
      default: tf_decode = 6'b000000;
    endcase
  endfunction : tf_decode

  // ==========================================================
  // pin synchronisers; first stage feeds only the second
  logic [15:0] dd_m_q, dd_s_q;
  logic        ack_m_q, ack_s_q, eot_m_q, eot_s_q;
  always_ff @(posedge CLK) begin
    if (RST) begin
      dd_m_q  <= 16'h0000;
      dd_s_q  <= 16'h0000;
      ack_m_q <= 1'b0;
      ack_s_q <= 1'b0;
      eot_m_q <= 1'b0;
      eot_s_q <= 1'b0;
    end else begin
      dd_m_q  <= DD_I;
      dd_s_q  <= dd_m_q;
      ack_m_q <= DMA_ACKNOWLEDGE_I;
      ack_s_q <= ack_m_q;
      eot_m_q <= END_OF_TRANSFER_INPUT;
      eot_s_q <= eot_m_q;
    end
  end

  // ==========================================================
  // state
  hsc_state_t  state_q, state_d;
  logic [7:0]  hw_q, hw_d;
  logic [4:0]  stb_q, stb_d;
  logic [3:0]  ctl_q, ctl_d;
  logic        aw_q, aw_d, w_q, w_d, ar_q, ar_d;
  logic [7:0]  awidx_q, awidx_d, aridx_q, aridx_d;
  logic [15:0] wdata_q, wdata_d;
  logic        wlane_q, wlane_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic        pio_wr_q, pio_wr_d, dma_rd_q, dma_rd_d;
  logic        phase_q, phase_d;
  logic [7:0]  lo_buf_q, lo_buf_d, hi_buf_q, hi_buf_d;
  logic [4:0]  sel_q, sel_d;
  logic [15:0] dd_o_q, dd_o_d, rx_q, rx_d;
  logic        dd_oe_n_q, dd_oe_n_d, rx_vld_q, rx_vld_d;
  logic        tf_1f0_q, tf_1f0_d;
  logic        tmr_start, tmr_busy, tmr_done;
  logic [5:0]  tmr_len;
  logic [5:0]  wdec, rdec;
  logic        wide, swap, wr_go, rd_go;
  logic [15:0] tx_sw;

  hsc_strobe_timer #(.LW(6)) u_tmr (
    .clk   (CLK),
    .rst   (RST),
    .start (tmr_start),
    .len   (tmr_len),
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

  assign wide  = ctl_q[`HSC_CTL_WIDE];
  // swap only for code 01 on a wide dma bus
  assign swap  = wide && hw_q[`HSC_SWAP_HI:`HSC_SWAP_LO]
                 == `HSC_SWAP_SWAPPED;
  assign tx_sw = swap ? {DMA_TX_DATA[7:0], DMA_TX_DATA[15:8]}
                      : DMA_TX_DATA;
  assign wdec  = tf_decode(awidx_q);
  assign rdec  = tf_decode(aridx_q);
  // writes win over reads when both wait
  assign wr_go = state_q == HSC_IDLE && aw_q && w_q;
  assign rd_go = state_q == HSC_IDLE && ar_q && !wr_go;

  // ==========================================================
  // bus slave, register file and transfer sequencing
  always_comb begin
    state_d = state_q;  hw_d = hw_q;  stb_d = stb_q;  ctl_d = ctl_q;
    aw_d = aw_q;  w_d = w_q;  ar_d = ar_q;
    awidx_d = awidx_q;  aridx_d = aridx_q;
    wdata_d = wdata_q;  wlane_d = wlane_q;  rdata_d = rdata_q;
    bresp_d = bresp_q;  rresp_d = rresp_q;
    pio_wr_d = pio_wr_q;  dma_rd_d = dma_rd_q;  phase_d = phase_q;
    lo_buf_d = lo_buf_q;  hi_buf_d = hi_buf_q;  sel_d = sel_q;
    dd_o_d = dd_o_q;  dd_oe_n_d = dd_oe_n_q;  rx_d = rx_q;
    rx_vld_d = 1'b0;  tf_1f0_d = tf_1f0_q;
    tmr_start = 1'b0;  tmr_len = PIO_LEN;
    if (S_AXI_AWVALID && !aw_q) begin
      aw_d    = 1'b1;
      awidx_d = S_AXI_AWADDR[9:2];
    end
    if (S_AXI_WVALID && !w_q) begin
      w_d     = 1'b1;
      wdata_d = S_AXI_WDATA[15:0];
      wlane_d = S_AXI_WSTRB[0];
    end
    if (S_AXI_ARVALID && !ar_q) begin
      ar_d    = 1'b1;
      aridx_d = S_AXI_ARADDR[9:2];
    end
    unique case (state_q)
      HSC_IDLE: begin
        if (wr_go) begin
          state_d = HSC_WRESP;
          bresp_d = `HSC_RESP_OKAY;
          if (wdec[5]) begin
            if (wlane_q) begin
              // eight-bit data port pairs low then high
              if (awidx_q == `HSC_IDX_TF_1F0 && !wide && !phase_q) begin
                lo_buf_d = wdata_q[7:0];
                phase_d  = 1'b1;
              end else begin
                // task file write becomes a pio write
                // chip selects and address from the index
                sel_d     = wdec[4:0];
                pio_wr_d  = 1'b1;
                phase_d   = 1'b0;
                dd_oe_n_d = 1'b0;
                dd_o_d    = wide ? wdata_q
                          : (awidx_q == `HSC_IDX_TF_1F0)
                          ? {wdata_q[7:0], lo_buf_q}
                          : {8'h00, wdata_q[7:0]};
                tmr_start = 1'b1;
                tmr_len   = PIO_LEN;
                state_d   = HSC_PIO;
              end
            end
          end else if (awidx_q == `HSC_IDX_HWCFG) begin
            if (wlane_q) hw_d = wdata_q[7:0];
          end else if (awidx_q == `HSC_IDX_STROBE) begin
            // only the five count bits are stored
            if (wlane_q) stb_d = wdata_q[4:0];
          end else if (awidx_q == `HSC_IDX_CTRL) begin
            if (wlane_q) begin
              ctl_d = wdata_q[3:0];
              // only the master role may run its own dma strobes
              if (wdata_q[`HSC_CTL_GO] && hw_q[`HSC_MASTER]) begin
                dma_rd_d  = wdata_q[`HSC_CTL_DIR];
                dd_oe_n_d = wdata_q[`HSC_CTL_DIR];
                dd_o_d    = tx_sw;
                tmr_start = 1'b1;
                // programmed length only in mode 03
                // mode 03 strobe is count plus one
                tmr_len   = (wdata_q[`HSC_CTL_MODE_HI:`HSC_CTL_MODE_LO]
                             == `HSC_MODE_PROG)
                            ? {1'b0, stb_q} + 6'd1 : DMA_LEN;
                state_d   = HSC_DMA;
              end
            end
          end else if (awidx_q != `HSC_IDX_STAT) begin
            bresp_d = `HSC_RESP_SLVERR;
          end
        end else if (rd_go) begin
          state_d  = HSC_RRESP;
          rresp_d  = `HSC_RESP_OKAY;
          rdata_d  = 32'h0000_0000;
          tf_1f0_d = aridx_q == `HSC_IDX_TF_1F0;
          if (aridx_q == `HSC_IDX_TF_1F7) begin
            rdata_d = {24'h000000, `HSC_TF_CMD_READ};
          end else if (rdec[5]) begin
            if (aridx_q == `HSC_IDX_TF_1F0 && !wide && phase_q) begin
              // second byte of the pair comes from the buffer
              rdata_d = {24'h000000, hi_buf_q};
              phase_d = 1'b0;
            end else begin
              // task file read becomes a pio read
              sel_d     = rdec[4:0];
              pio_wr_d  = 1'b0;
              dd_oe_n_d = 1'b1;
              tmr_start = 1'b1;
              tmr_len   = PIO_LEN;
              state_d   = HSC_PIO;
            end
          end else if (aridx_q == `HSC_IDX_HWCFG) begin
            rdata_d = {24'h000000, hw_q};
          end else if (aridx_q == `HSC_IDX_STROBE) begin
            rdata_d = {27'h0000000, stb_q};
          end else if (aridx_q == `HSC_IDX_CTRL) begin
            rdata_d = {28'h0000000, ctl_q};
          end else if (aridx_q == `HSC_IDX_STAT) begin
            rdata_d = {rx_q, 14'h0000, DMA_EOT_SEEN, tmr_busy};
          end else begin
            rresp_d = `HSC_RESP_SLVERR;
          end
        end
      end
      HSC_PIO: begin
        if (tmr_done) begin
          dd_oe_n_d = 1'b1;
          if (pio_wr_q) begin
            state_d = HSC_WRESP;
          end else begin
            state_d = HSC_RRESP;
            if (wide) begin
              rdata_d = {16'h0000, dd_s_q};
            end else begin
              rdata_d = {24'h000000, dd_s_q[7:0]};
              if (tf_1f0_q) begin
                hi_buf_d = dd_s_q[15:8];
                phase_d  = 1'b1;
              end
            end
          end
        end
      end
      HSC_DMA: begin
        if (tmr_done) begin
          dd_oe_n_d = 1'b1;
          state_d   = HSC_WRESP;
          if (dma_rd_q) begin
            // received word takes the same lane order
            rx_d     = swap ? {dd_s_q[7:0], dd_s_q[15:8]} : dd_s_q;
            rx_vld_d = 1'b1;
          end
        end
      end
      HSC_WRESP: begin
        if (S_AXI_BREADY) begin
          aw_d    = 1'b0;
          w_d     = 1'b0;
          state_d = HSC_IDLE;
        end
      end
      HSC_RRESP: begin
        if (S_AXI_RREADY) begin
          ar_d    = 1'b0;
          state_d = HSC_IDLE;
        end
      end
      default: state_d = HSC_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= HSC_IDLE;  hw_q <= `HSC_HWCFG_RST;
      stb_q <= `HSC_STB_RST;  ctl_q <= 4'h0;
      aw_q <= 1'b0;  w_q <= 1'b0;  ar_q <= 1'b0;
      awidx_q <= 8'h00;  aridx_q <= 8'h00;
      wdata_q <= 16'h0000;  wlane_q <= 1'b0;  rdata_q <= 32'h0;
      bresp_q <= 2'h0;  rresp_q <= 2'h0;
      pio_wr_q <= 1'b0;  dma_rd_q <= 1'b0;  phase_q <= 1'b0;
      lo_buf_q <= 8'h00;  hi_buf_q <= 8'h00;  sel_q <= 5'h00;
      dd_o_q <= 16'h0000;  dd_oe_n_q <= 1'b1;  rx_q <= 16'h0000;
      rx_vld_q <= 1'b0;  tf_1f0_q <= 1'b0;
    end else begin
      state_q <= state_d;  hw_q <= hw_d;  stb_q <= stb_d;
      ctl_q <= ctl_d;  aw_q <= aw_d;  w_q <= w_d;  ar_q <= ar_d;
      awidx_q <= awidx_d;  aridx_q <= aridx_d;
      wdata_q <= wdata_d;  wlane_q <= wlane_d;  rdata_q <= rdata_d;
      bresp_q <= bresp_d;  rresp_q <= rresp_d;
      pio_wr_q <= pio_wr_d;  dma_rd_q <= dma_rd_d;  phase_q <= phase_d;
      lo_buf_q <= lo_buf_d;  hi_buf_q <= hi_buf_d;  sel_q <= sel_d;
      dd_o_q <= dd_o_d;  dd_oe_n_q <= dd_oe_n_d;  rx_q <= rx_d;
      rx_vld_q <= rx_vld_d;  tf_1f0_q <= tf_1f0_d;
    end
  end

  // ==========================================================
  // pins: polarity folded into flops so a change never glitches
  logic rd_act, wr_act, ack_act;
  logic rd_pin_q, wr_pin_q, req_pin_q, ack_pin_q, ack_seen_q, eot_q;
  assign rd_act  = tmr_busy && ((state_q == HSC_PIO && !pio_wr_q) ||
                   (state_q == HSC_DMA && dma_rd_q));
  assign wr_act  = tmr_busy && ((state_q == HSC_PIO && pio_wr_q) ||
                   (state_q == HSC_DMA && !dma_rd_q));
  assign ack_act = tmr_busy && state_q == HSC_DMA;
  always_ff @(posedge CLK) begin
    if (RST) begin
      rd_pin_q   <= 1'b1;
      wr_pin_q   <= 1'b1;
      req_pin_q  <= 1'b0;
      ack_pin_q  <= 1'b1;
      ack_seen_q <= 1'b0;
      eot_q      <= 1'b0;
    end else begin
      // active-high internals meet polarity at the pin flop
      rd_pin_q   <= rd_act ^ ~hw_q[`HSC_RD_POL];
      wr_pin_q   <= wr_act ^ ~hw_q[`HSC_WR_POL];
      req_pin_q  <= DMA_REQ_IN ^ ~hw_q[`HSC_REQ_POL];
      ack_pin_q  <= ack_act ^ ~hw_q[`HSC_ACKNOWLEDGE_POLARITY];
      ack_seen_q <= !hw_q[`HSC_MASTER] &&
                    (ack_s_q ^ ~hw_q[`HSC_ACKNOWLEDGE_POLARITY]);
      // end of transfer sensed in slave role only
      eot_q      <= !hw_q[`HSC_MASTER] &&
                    (eot_s_q ^ ~hw_q[`HSC_END_OF_TRANSFER_POLARITY]);
    end
  end

  assign DEVICE_IO_READ_STROBE  = rd_pin_q;
  assign DEVICE_IO_WRITE_STROBE = wr_pin_q;
  assign DMA_REQUEST            = req_pin_q;
  assign DMA_ACKNOWLEDGE_O      = ack_pin_q;
  // acknowledge is driven only in the master role
  assign DMA_ACKNOWLEDGE_OE_N   = ~hw_q[`HSC_MASTER];
  assign DMA_ACK_SEEN           = ack_seen_q;
  assign DMA_EOT_SEEN           = eot_q;
  assign {TF_CS1, TF_CS0, TF_DA} = sel_q;
  assign DD_O                   = dd_o_q;
  assign DD_OE_N                = dd_oe_n_q;
  assign DMA_RX_DATA            = rx_q;
  assign DMA_RX_VALID           = rx_vld_q;
  assign S_AXI_AWREADY          = !aw_q;
  assign S_AXI_WREADY           = !w_q;
  assign S_AXI_ARREADY          = !ar_q;
  assign S_AXI_BVALID           = state_q == HSC_WRESP;
  assign S_AXI_BRESP            = bresp_q;
  assign S_AXI_RVALID           = state_q == HSC_RRESP;
  assign S_AXI_RRESP            = rresp_q;
  assign S_AXI_RDATA            = rdata_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_prog_go;
    wr_go && wlane_q && awidx_q == `HSC_IDX_CTRL &&
    wdata_q[`HSC_CTL_GO] && hw_q[`HSC_MASTER] &&
    wdata_q[`HSC_CTL_MODE_HI:`HSC_CTL_MODE_LO] == `HSC_MODE_PROG;
  endsequence
  sequence s_tf_write;
    wr_go && wlane_q && wdec[5] &&
    !(awidx_q == `HSC_IDX_TF_1F0 && !wide && !phase_q);
  endsequence
  AST_PROG_LEN: assert property (
    s_prog_go |-> tmr_len == {1'b0, stb_q} + 6'd1)
    else $error("programmed strobe length not count plus one");
  AST_DEF_LEN: assert property (
    (tmr_start && state_q == HSC_IDLE && wr_go && wlane_q &&
     awidx_q == `HSC_IDX_CTRL &&
     wdata_q[`HSC_CTL_MODE_HI:`HSC_CTL_MODE_LO] != `HSC_MODE_PROG)
    |-> tmr_len == DMA_LEN)
    else $error("strobe length used outside mode 03");
  AST_TF_SEL: assert property (
    s_tf_write ##1 1'b1 |-> sel_q == $past(wdec[4:0]))
    else $error("task file selects do not match register");
  AST_PAIR_FIRST: assert property (
    (wr_go && wlane_q && awidx_q == `HSC_IDX_TF_1F0 && !wide &&
     !phase_q) |=> state_q == HSC_WRESP && !tmr_busy)
    else $error("first data byte issued a pio cycle");
  AST_CMD_READ: assert property (
    (S_AXI_RVALID && aridx_q == `HSC_IDX_TF_1F7)
    |-> S_AXI_RDATA[7:0] == `HSC_TF_CMD_READ)
    else $error("command register read not ff");
  AST_RST_STB: assert property (
    $past(RST) |-> stb_q == `HSC_STB_RST && hw_q == `HSC_HWCFG_RST)
    else $error("strobe count reset value wrong");
  AST_REQ_POL: assert property (
    $past(!RST) |-> DMA_REQUEST ==
    ($past(DMA_REQ_IN) ^ ~$past(hw_q[`HSC_REQ_POL])))
    else $error("request pin level wrong");
  AST_RD_POL: assert property (
    $past(!RST) |-> DEVICE_IO_READ_STROBE ==
    ($past(rd_act) ^ ~$past(hw_q[`HSC_RD_POL])))
    else $error("read strobe level wrong");
  AST_WR_POL: assert property (
    $past(!RST) |-> DEVICE_IO_WRITE_STROBE ==
    ($past(wr_act) ^ ~$past(hw_q[`HSC_WR_POL])))
    else $error("write strobe level wrong");
  AST_SWAP_TX: assert property (
    (s_prog_go and (!wdata_q[`HSC_CTL_DIR] && swap))
    |=> DD_O == {$past(DMA_TX_DATA[7:0]), $past(DMA_TX_DATA[15:8])})
    else $error("transmit lanes not swapped");
  AST_ACK_ROLE: assert property (
    !hw_q[`HSC_MASTER] |-> DMA_ACKNOWLEDGE_OE_N && !ack_act)
    else $error("slave role drives acknowledge");
endmodule : hsc_dma_bus_handshake

// file: hsc_drive_model.sv
// far-side model: drive registers and dma partner on the pins
`timescale 1ns/1ps
module hsc_drive_model (
  input  wire logic        clk,
  input  wire logic        rd_act,
  input  wire logic        wr_act,
  input  wire logic [4:0]  sel,
  input  wire logic [15:0] dd_o,
  input  wire logic        dd_oe_n,
  input  wire logic [15:0] word,
  output logic [15:0]      dd_i,
  output logic [4:0]       wr_sel,
  output logic [15:0]      wr_word,
  output int               wr_cnt
);
  int   hold = 0;
  logic tick = 1'b0;
  logic wr_q = 1'b0;
  // data held three cycles past the read strobe, then a moving pattern
  assign dd_i = (rd_act || hold > 0) ? word : ~word ^ {16{tick}};
  initial wr_cnt = 0;
  // capture each pio write, count it when its strobe ends
  always @(posedge clk) begin
    tick <= ~tick;
    hold <= rd_act ? 3 : (hold > 0 ? hold - 1 : 0);
    wr_q <= wr_act;
    if (wr_act && !dd_oe_n) begin
      wr_word <= dd_o;
      wr_sel <= sel;
    end
    if (wr_q && !wr_act) wr_cnt <= wr_cnt + 1;
  end
endmodule : hsc_drive_model

// file: hsc_dma_bus_handshake_tb.sv
// self-checking bench for the dma handshake configuration block
`timescale 1ns/1ps
`define CHK(a,b) begin checked++; if ((a)!==(b)) begin err_total++; \
  $display("mismatch %0t got %h exp %h", $time, a, b); end end
module hsc_dma_bus_handshake_tb;
  logic CLK, RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID;
  logic S_AXI_RREADY, DMA_REQ_IN, ack_ext, END_OF_TRANSFER_INPUT;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, DMA_RX_VALID, DMA_ACK_SEEN, DMA_EOT_SEEN, DMA_REQUEST;
  logic DMA_ACKNOWLEDGE_O, DMA_ACKNOWLEDGE_OE_N, DEVICE_IO_READ_STROBE;
  logic DEVICE_IO_WRITE_STROBE, TF_CS1, TF_CS0, DD_OE_N;
  logic [9:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd, d, seed;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rsp;
  logic [15:0] DMA_TX_DATA, DMA_RX_DATA, DD_O, drv_dd, word, wr_word;
  logic [2:0]  TF_DA;
  logic [4:0]  wr_sel;
  logic [7:0]  hw, v;
  int err_total = 0, checked = 0, wr_cnt, plen = 0, run = 0, n, c;
  int rxv = 0;
  logic [7:0] tfi [10] = '{8'h40, 8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c,
                           8'h4d, 8'h4e, 8'h4f, 8'h44};
  logic [4:0] tfs [10] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15,
                           5'h16, 5'h0e, 5'h0f, 5'h17};
  // shared pins resolve from whoever drives them
  wire DMA_ACKNOWLEDGE_I = DMA_ACKNOWLEDGE_OE_N ? ack_ext : DMA_ACKNOWLEDGE_O;
  wire [15:0] DD_I = DD_OE_N ? drv_dd : DD_O;
  hsc_drive_model u_drv (.clk(CLK), .rd_act(DEVICE_IO_READ_STROBE == hw[0]),
    .wr_act(DEVICE_IO_WRITE_STROBE == hw[1]), .sel({TF_CS1, TF_CS0, TF_DA}),
    .dd_o(DD_O), .dd_oe_n(DD_OE_N), .word(word), .dd_i(drv_dd),
    .wr_sel(wr_sel), .wr_word(wr_word), .wr_cnt(wr_cnt));
  hsc_dma_bus_handshake u_dut (.*);
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  // length of the last active read strobe pulse, and words received
  always @(posedge CLK) begin
    if (DMA_RX_VALID) rxv <= rxv + 1;
    if (DEVICE_IO_READ_STROBE == hw[0]) run <= run + 1;
    else begin
      if (run > 0) plen <= run;
      run <= 0;
    end
  end
  task automatic test_done;
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  // one axi-lite access; valid held until its ready, answer awaited
  task automatic acc(input logic w, input logic [7:0] idx,
                     input logic [31:0] dw);
    logic ta, tw, tr, dn;
    S_AXI_AWADDR <= {idx, 2'b00};
    S_AXI_ARADDR <= {idx, 2'b00};
    S_AXI_WDATA <= dw;
    S_AXI_AWVALID <= w;
    S_AXI_WVALID <= w;
    S_AXI_ARVALID <= !w;
    S_AXI_BREADY <= w;
    S_AXI_RREADY <= !w;
    do begin
      @(negedge CLK);
      ta = S_AXI_AWVALID && S_AXI_AWREADY;
      tw = S_AXI_WVALID && S_AXI_WREADY;
      tr = S_AXI_ARVALID && S_AXI_ARREADY;
      dn = w ? S_AXI_BVALID : S_AXI_RVALID;
      rsp = w ? S_AXI_BRESP : S_AXI_RRESP;
      rd = S_AXI_RDATA;
      @(posedge CLK);
      if (ta) S_AXI_AWVALID <= 1'b0;
      if (tw) S_AXI_WVALID <= 1'b0;
      if (tr) S_AXI_ARVALID <= 1'b0;
    end while (!dn);
    S_AXI_BREADY <= 1'b0;
    S_AXI_RREADY <= 1'b0;
    // one edge apart, so a following call never reassigns them at once
    @(posedge CLK);
  endtask : acc
  // watchdog: far beyond the few hundred cycles the run needs
  initial begin
    #2000000;
    err_total++;
    test_done;
  end
  initial begin
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID} = 4'h0;
    {S_AXI_RREADY, DMA_REQ_IN, ack_ext, END_OF_TRANSFER_INPUT} = 4'h0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
    S_AXI_WSTRB = 4'hf;
    seed = 32'h6681;
    DMA_TX_DATA = 16'h0;
    word = 16'h0;
    hw = 8'h04;
    RST = 1'b1;
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    acc(0, 8'h3c, 0);
    `CHK(rd[7:0], 8'h04)
    acc(1, 8'h60, 32'hff);
    acc(0, 8'h60, 0);
    `CHK(rd[7:0], 8'h1f)
    acc(0, 8'h44, 0);
    `CHK(rd[7:0], 8'hff)
    acc(0, 8'h70, 0);
    `CHK(rsp, 2'h2)
    acc(1, 8'h38, 32'h4);
    // random role and polarities, pins judged against their levels
    for (int i = 0; i < 16; i++) begin
      v = 8'($random(seed)) & 8'h7f;
      acc(1, 8'h3c, {24'h0, v});
      hw = v;
      DMA_REQ_IN <= 1'($random(seed));
      ack_ext <= 1'($random(seed));
      END_OF_TRANSFER_INPUT <= 1'($random(seed));
      DMA_TX_DATA <= 16'($random(seed));
      repeat (4) @(posedge CLK);
      acc(0, 8'h3c, 0);
      `CHK(rd[7:0], v)
      `CHK(DEVICE_IO_READ_STROBE, ~v[0])
      `CHK(DEVICE_IO_WRITE_STROBE, ~v[1])
      `CHK(DMA_REQUEST, DMA_REQ_IN ^ ~v[2])
      `CHK(DMA_ACKNOWLEDGE_OE_N, ~v[4])
      if (v[4]) `CHK(DMA_ACKNOWLEDGE_O, ~v[3])
      else `CHK(DMA_ACK_SEEN, ack_ext ~^ v[3])
      if (!v[4]) `CHK(DMA_EOT_SEEN, END_OF_TRANSFER_INPUT ~^ v[5])
    end
    // master reads with swapped lanes; last one in a fixed-timing mode
    acc(1, 8'h3c, 32'h50);
    hw = 8'h50;
    for (int i = 0; i < 4; i++) begin
      n = (i == 0) ? 0 : (i == 1) ? 31 : 4 + ($random(seed) & 15);
      word = 16'($random(seed));
      acc(1, 8'h60, n);
      acc(1, 8'h38, (i == 3) ? 32'h1c : 32'h1f);
      repeat (3) @(posedge CLK);
      `CHK(plen, (i == 3) ? 3 : n + 1)
      if (i < 3 && n > 2) `CHK(DMA_RX_DATA, {word[7:0], word[15:8]})
      `CHK(rxv, i + 1)
    end
    // master write drives the swapped word on the data lines
    DMA_TX_DATA <= 16'($random(seed));
    c = wr_cnt;
    acc(1, 8'h38, 32'h17);
    repeat (2) @(posedge CLK);
    `CHK(wr_cnt, c + 1)
    `CHK(wr_word, {DMA_TX_DATA[7:0], DMA_TX_DATA[15:8]})
    // every task file register, command register last
    acc(1, 8'h3c, 32'h03);
    hw = 8'h03;
    for (int k = 0; k < 10; k++) begin
      c = wr_cnt;
      d = $random(seed);
      acc(1, tfi[k], d);
      repeat (2) @(posedge CLK);
      `CHK(wr_cnt, c + 1)
      `CHK(wr_sel, tfs[k])
      `CHK(wr_word[7:0], d[7:0])
    end
    // eight-bit bus: data port pairs two byte accesses, low first
    acc(1, 8'h38, 32'h0);
    c = wr_cnt;
    acc(1, 8'h40, 32'h5a);
    repeat (2) @(posedge CLK);
    `CHK(wr_cnt, c)
    acc(1, 8'h40, 32'hc3);
    repeat (2) @(posedge CLK);
    `CHK(wr_word, 16'hc35a)
    word = 16'($random(seed));
    acc(0, 8'h40, 0);
    `CHK(rd[7:0], word[7:0])
    acc(0, 8'h40, 0);
    `CHK(rd[7:0], word[15:8])
    test_done;
  end
endmodule : hsc_dma_bus_handshake_tb
